//--- hw/acl_action_defs.svh
// offsets, field positions, reset values and write mask of the rule action stage
`ifndef ACL_ACTION_DEFS_SVH
`define ACL_ACTION_DEFS_SVH

`define ADDR_IND_CTRL 8'h6e
`define ADDR_IND_OFFS 8'h6f
`define ADDR_IND_DATA 8'ha0
`define TABLE_CODE_ACL 3'h2
`define OFFS_PRIO_BYTE 8'h0a
`define OFFS_MAP_BYTE 8'h0b
`define PRIO_MODE_HI 7
`define PRIO_MODE_LO 6
`define PRIO_VAL_HI 5
`define PRIO_VAL_LO 3
`define REMARK_EN_BIT 2
`define REMARK_HI 1
`define REMARK_LO 0
`define MAP_MODE_HI 6
`define MAP_MODE_LO 5
`define MAP_HI 4
`define MAP_LO 0
`define RESET_BYTE 8'h00
`define MAP_WRITE_MASK 8'h7f
`define MAP_RESERVED_BIT 3

`endif

//--- hw/acl_action_pkg.sv
// types of the rule action stage
package acl_action_pkg;
    typedef enum logic [1:0] {
        prio_keep = 2'h0,
        prio_if_greater = 2'h1,
        prio_if_smaller = 2'h2,
        prio_replace = 2'h3
    } prio_mode_type;
    typedef enum logic [1:0] {
        map_lut_only = 2'h0,
        map_or = 2'h1,
        map_and = 2'h2,
        map_replace = 2'h3
    } map_mode_type;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_hold = 3'b010,
        st_out = 3'b100
    } stage_state_type;
endpackage

//--- hw/acl_action_if.sv
// action fields shared between the register file and the decision logic
`timescale 1ns/100ps
interface acl_action_if;
    import acl_action_pkg::*;
    prio_mode_type priority_select_mode;
    logic [2:0] rule_priority;
    logic remark_enable;
    logic [1:0] remark_priority_value;
    map_mode_type forward_map_mode;
    logic [4:0] rule_port_map;
    modport regs (output priority_select_mode, rule_priority, remark_enable,
        remark_priority_value, forward_map_mode, rule_port_map);
    modport user (input priority_select_mode, rule_priority, remark_enable,
        remark_priority_value, forward_map_mode, rule_port_map);
endinterface

//--- hw/acl_action_regs.sv
// indirect byte access to the action bytes of each port's rule entry
`timescale 1ns/100ps
`include "acl_action_defs.svh"
module acl_action_regs #(
    parameter int PORTS = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] sel_port,
    input wire logic bus_wr,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    acl_action_if.regs act
);
    import acl_action_pkg::*;
    logic [7:0] ctrl, offs;
    logic [7:0] next_ctrl, next_offs;
    logic [7:0] prio_byte [PORTS];
    logic [7:0] map_byte [PORTS];
    logic [7:0] next_prio_byte [PORTS];
    logic [7:0] next_map_byte [PORTS];
    logic [1:0] ind_port;
    logic acl_sel, ind_ok;

    assign ind_port = ctrl[1:0] - 2'h1;
    assign acl_sel = ctrl[7:5] == `TABLE_CODE_ACL && ctrl[3:0] >= 4'h1
        && ctrl[3:0] <= 4'(PORTS);
    assign ind_ok = acl_sel && bus_addr == `ADDR_IND_DATA;

    always_comb begin
        next_ctrl = ctrl;
        next_offs = offs;
        next_prio_byte = prio_byte;
        next_map_byte = map_byte;
        bus_rdata = 8'h00;
        if (bus_wr && bus_addr == `ADDR_IND_CTRL) begin
            next_ctrl = bus_wdata;
        end
        if (bus_wr && bus_addr == `ADDR_IND_OFFS) begin
            next_offs = bus_wdata;
        end
        if (bus_wr && ind_ok && offs == `OFFS_PRIO_BYTE) begin
            next_prio_byte[ind_port] = bus_wdata;
        end
        if (bus_wr && ind_ok && offs == `OFFS_MAP_BYTE) begin
            next_map_byte[ind_port] = bus_wdata & `MAP_WRITE_MASK;
        end
        case (bus_addr)
            `ADDR_IND_CTRL: bus_rdata = ctrl;
            `ADDR_IND_OFFS: bus_rdata = offs;
            `ADDR_IND_DATA: begin
                if (acl_sel && offs == `OFFS_PRIO_BYTE) begin
                    bus_rdata = prio_byte[ind_port];
                end else if (acl_sel && offs == `OFFS_MAP_BYTE) begin
                    bus_rdata = map_byte[ind_port];
                end
            end
            default: bus_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= `RESET_BYTE;
            offs <= `RESET_BYTE;
            for (int i = 0; i < PORTS; i++) begin
                prio_byte[i] <= `RESET_BYTE;
                map_byte[i] <= `RESET_BYTE;
            end
        end else begin
            ctrl <= next_ctrl;
            offs <= next_offs;
            prio_byte <= next_prio_byte;
            map_byte <= next_map_byte;
        end
    end

    assign act.priority_select_mode =
        prio_mode_type'(prio_byte[sel_port][`PRIO_MODE_HI:`PRIO_MODE_LO]);
    assign act.rule_priority = prio_byte[sel_port][`PRIO_VAL_HI:`PRIO_VAL_LO];
    assign act.remark_enable = prio_byte[sel_port][`REMARK_EN_BIT];
    assign act.remark_priority_value = prio_byte[sel_port][`REMARK_HI:`REMARK_LO];
    assign act.forward_map_mode =
        map_mode_type'(map_byte[sel_port][`MAP_MODE_HI:`MAP_MODE_LO]);
    assign act.rule_port_map = map_byte[sel_port][`MAP_HI:`MAP_LO];

    reset_prio_a: assert property (@(posedge clk) !rst_n |=> prio_byte[0] == 8'h00)
        else $error("priority byte not cleared by reset");
    ind_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_wr && ind_ok && offs == 8'h0a |=> prio_byte[$past(ind_port)] == $past(bus_wdata))
        else $error("priority byte write lost");
    map_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
        map_byte[0][7] == 1'b0)
        else $error("map byte top bit set");
endmodule

//--- hw/acl_action_decide.sv
// priority and forwarding decision of one matched rule entry
`timescale 1ns/100ps
module acl_action_decide (
    input wire logic [2:0] qos_priority,
    input wire logic [4:0] lut_map,
    acl_action_if.user act,
    output logic [2:0] dec_priority,
    output logic [4:0] dec_map
);
    import acl_action_pkg::*;

    function automatic logic [4:0] clean_map(input logic [4:0] m);
        clean_map = m & 5'h17;
    endfunction

    always_comb begin
        case (act.priority_select_mode)
            prio_keep: dec_priority = qos_priority;
            prio_if_greater: dec_priority = (act.rule_priority > qos_priority) ?
                act.rule_priority : qos_priority;
            prio_if_smaller: dec_priority = (act.rule_priority < qos_priority) ?
                act.rule_priority : qos_priority;
            prio_replace: dec_priority = act.rule_priority;
            default: dec_priority = qos_priority;
        endcase
        case (act.forward_map_mode)
            map_lut_only: dec_map = lut_map;
            map_or: dec_map = lut_map | clean_map(act.rule_port_map);
            map_and: dec_map = lut_map & clean_map(act.rule_port_map);
            map_replace: dec_map = clean_map(act.rule_port_map);
            default: dec_map = lut_map;
        endcase
    end
endmodule

//--- hw/acl_action_top.sv
// rule action stage: indirect action bytes plus per-packet priority and map decision
`timescale 1ns/100ps
`include "acl_action_defs.svh"
module acl_action_top #(
    parameter int PORTS = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access
    input wire logic bus_wr,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    // packet in
    input wire logic pkt_valid,
    input wire logic [1:0] pkt_port,
    input wire logic pkt_match,
    input wire logic pkt_tagged,
    input wire logic [2:0] qos_priority,
    input wire logic [2:0] vlan_priority,
    input wire logic [4:0] lut_map,
    // decision out
    output logic out_valid,
    output logic [2:0] out_priority,
    output logic [2:0] out_vlan_priority,
    output logic [4:0] out_map
);
    import acl_action_pkg::*;
    acl_action_if act ();
    logic [2:0] dec_priority;
    logic [4:0] dec_map;
    logic [2:0] next_priority, next_vlan;
    logic [4:0] next_map;
    logic next_valid;

    acl_action_regs #(.PORTS(PORTS)) regs_i (
        .clk(clk),
        .rst_n(rst_n),
        .sel_port(pkt_port),
        .bus_wr(bus_wr),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata),
        .act(act.regs)
    );

    acl_action_decide decide_i (
        .qos_priority(qos_priority),
        .lut_map(lut_map),
        .act(act.user),
        .dec_priority(dec_priority),
        .dec_map(dec_map)
    );

    // ==========================================================
    // registered decision
    always_comb begin
        next_valid = pkt_valid;
        next_priority = qos_priority;
        next_vlan = vlan_priority;
        next_map = lut_map;
        if (pkt_valid && pkt_match) begin
            next_map = dec_map;
            if (pkt_tagged) begin
                next_priority = dec_priority;
            end
            if (act.remark_enable) begin
                next_vlan = {1'b0, act.remark_priority_value};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_priority <= 3'h0;
            out_vlan_priority <= 3'h0;
            out_map <= 5'h00;
        end else begin
            out_valid <= next_valid;
            out_priority <= next_priority;
            out_vlan_priority <= next_vlan;
            out_map <= next_map;
        end
    end

    // ==========================================================
    // checks
    valid_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> out_valid == $past(pkt_valid))
        else $error("decision valid not one cycle after request");
    nomatch_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && !pkt_match |=> out_map == $past(lut_map)
        && out_priority == $past(qos_priority)
        && out_vlan_priority == $past(vlan_priority))
        else $error("unmatched packet altered");
    replace_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && act.forward_map_mode == map_replace
        |=> out_map == ($past(act.rule_port_map) & 5'h17))
        else $error("map replace wrong");
    or_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && act.forward_map_mode == map_or
        |=> out_map == ($past(lut_map) | ($past(act.rule_port_map) & 5'h17)))
        else $error("or map wrong");
    and_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && act.forward_map_mode == map_and
        |=> out_map == ($past(lut_map) & $past(act.rule_port_map) & 5'h17))
        else $error("and map wrong");
    keep_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && act.forward_map_mode == map_lut_only
        |=> out_map == $past(lut_map))
        else $error("look-up map not kept");
    keep_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && pkt_tagged
        && act.priority_select_mode == prio_keep
        |=> out_priority == $past(qos_priority))
        else $error("keep mode changed priority");
    greater_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && pkt_tagged
        && act.priority_select_mode == prio_if_greater
        |=> out_priority == (($past(act.rule_priority) > $past(qos_priority)) ?
        $past(act.rule_priority) : $past(qos_priority)))
        else $error("greater mode chose wrong priority");
    smaller_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && pkt_tagged
        && act.priority_select_mode == prio_if_smaller
        |=> out_priority == (($past(act.rule_priority) < $past(qos_priority)) ?
        $past(act.rule_priority) : $past(qos_priority)))
        else $error("smaller mode chose wrong priority");
    replace_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && pkt_tagged && act.priority_select_mode == prio_replace
        |=> out_priority == $past(act.rule_priority))
        else $error("priority not replaced");
    untag_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && !pkt_tagged
        |=> out_priority == $past(qos_priority))
        else $error("untagged packet priority changed");
    remark_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && act.remark_enable
        |=> out_vlan_priority == {1'b0, $past(act.remark_priority_value)})
        else $error("remark not applied");
    no_remark_a: assert property (@(posedge clk) disable iff (!rst_n)
        pkt_valid && pkt_match && !act.remark_enable
        |=> out_vlan_priority == $past(vlan_priority))
        else $error("vlan priority remarked while disabled");

    cov_remark: cover property (@(posedge clk) pkt_valid && pkt_match && act.remark_enable);
    cov_replace: cover property (@(posedge clk)
        pkt_valid && pkt_match && act.forward_map_mode == map_replace);
    cov_greater: cover property (@(posedge clk) pkt_valid && pkt_match && pkt_tagged
        && act.priority_select_mode == prio_if_greater);
    cov_and_map: cover property (@(posedge clk)
        pkt_valid && pkt_match && act.forward_map_mode == map_and);
    cov_untagged: cover property (@(posedge clk) pkt_valid && pkt_match && !pkt_tagged);
endmodule

//--- sim/acl_action_priority_forward_remap_tb.sv
// self-checking bench of the rule action stage
`timescale 1ns/100ps
`include "acl_action_defs.svh"
module acl_action_priority_forward_remap_tb;
    import acl_action_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_wr = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic pkt_valid = 1'b0;
    logic [1:0] pkt_port = 2'h0;
    logic pkt_match = 1'b0;
    logic pkt_tagged = 1'b0;
    logic [2:0] qos_priority = 3'h0;
    logic [2:0] vlan_priority = 3'h0;
    logic [4:0] lut_map = 5'h00;
    logic out_valid;
    logic [2:0] out_priority;
    logic [2:0] out_vlan_priority;
    logic [4:0] out_map;
    int err_count = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    acl_action_top #(.PORTS(4)) uut (.clk(clk), .rst_n(rst_n), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .pkt_valid(pkt_valid), .pkt_port(pkt_port), .pkt_match(pkt_match),
        .pkt_tagged(pkt_tagged), .qos_priority(qos_priority),
        .vlan_priority(vlan_priority), .lut_map(lut_map), .out_valid(out_valid),
        .out_priority(out_priority), .out_vlan_priority(out_vlan_priority), .out_map(out_map));
    // ==========================================
    // shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // write held one edge; caller releases the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_wr = 1'b1;
        bus_addr = a;
        bus_wdata = d;
        @(posedge clk);
        #1;
    endtask
    task automatic set_byte(input logic [7:0] ctrl, input logic [7:0] offs, input logic [7:0] d);
        wr(`ADDR_IND_CTRL, ctrl);
        wr(`ADDR_IND_OFFS, offs);
        wr(`ADDR_IND_DATA, d);
        bus_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] port, input logic [7:0] offs, input logic [7:0] exp);
        wr(`ADDR_IND_CTRL, {3'h2, 1'b0, port});
        wr(`ADDR_IND_OFFS, offs);
        bus_wr = 1'b0;
        bus_addr = `ADDR_IND_DATA;
        #1;
        chk(bus_rdata, exp, "indirect read");
        @(posedge clk);
        #1;
    endtask
    task automatic pkt(input logic [1:0] p, input logic m, input logic t, input logic [2:0] q,
        input logic [2:0] v, input logic [4:0] lm, input logic [2:0] ep, input logic [2:0] ev,
        input logic [4:0] em);
        pkt_valid = 1'b1;
        pkt_port = p;
        pkt_match = m;
        pkt_tagged = t;
        qos_priority = q;
        vlan_priority = v;
        lut_map = lm;
        @(posedge clk);
        #1;
        pkt_valid = 1'b0;
        chk({7'h0, out_valid}, 8'h01, "out valid");
        chk({5'h0, out_priority}, {5'h0, ep}, "priority");
        chk({5'h0, out_vlan_priority}, {5'h0, ev}, "vlan priority");
        chk({3'h0, out_map}, {3'h0, em}, "map");
        @(posedge clk);
        #1;
        chk({7'h0, out_valid}, 8'h00, "out valid pulse");
    endtask
    function automatic logic [2:0] exp_prio(input logic [1:0] m, input logic [2:0] r,
        input logic [2:0] q);
        case (m)
            2'h0: return q;
            2'h1: return (r > q) ? r : q;
            2'h2: return (r < q) ? r : q;
            default: return r;
        endcase
    endfunction
    // ==========================================
    // scenarios
    task automatic t_reset();
        for (int p = 1; p <= 4; p++) begin
            rd_chk(p[3:0], `OFFS_PRIO_BYTE, 8'h00);
            rd_chk(p[3:0], `OFFS_MAP_BYTE, 8'h00);
        end
        bus_addr = 8'h55;
        #1;
        chk(bus_rdata, 8'h00, "unmapped read");
        @(posedge clk);
        #1;
    endtask
    task automatic t_access();
        set_byte(8'h43, `OFFS_PRIO_BYTE, 8'hed);
        rd_chk(4'h3, `OFFS_PRIO_BYTE, 8'hed);
        set_byte(8'h43, `OFFS_MAP_BYTE, 8'hff);
        rd_chk(4'h3, `OFFS_MAP_BYTE, 8'h7f);
        bus_addr = `ADDR_IND_CTRL;
        #1;
        chk(bus_rdata, 8'h43, "control readback");
        @(posedge clk);
        #1;
        bus_addr = `ADDR_IND_OFFS;
        #1;
        chk(bus_rdata, `OFFS_MAP_BYTE, "offset readback");
        @(posedge clk);
        #1;
        rd_chk(4'h2, `OFFS_PRIO_BYTE, 8'h00);
        set_byte(8'h23, `OFFS_PRIO_BYTE, 8'h11);
        rd_chk(4'h3, `OFFS_PRIO_BYTE, 8'hed);
        set_byte(8'h43, 8'h0c, 8'h11);
        rd_chk(4'h3, 8'h0c, 8'h00);
        set_byte(8'h43, `OFFS_PRIO_BYTE, 8'h00);
        set_byte(8'h43, `OFFS_MAP_BYTE, 8'h00);
    endtask
    task automatic t_prio();
        for (int m = 0; m < 4; m++) begin
            set_byte(8'h41, `OFFS_PRIO_BYTE, {m[1:0], 3'h4, 3'h0});
            pkt(2'h0, 1'b1, 1'b1, 3'h2, 3'h1, 5'h07, exp_prio(m[1:0], 3'h4, 3'h2), 3'h1,
                5'h07);
            pkt(2'h0, 1'b1, 1'b1, 3'h6, 3'h1, 5'h07, exp_prio(m[1:0], 3'h4, 3'h6), 3'h1,
                5'h07);
            pkt(2'h0, 1'b1, 1'b1, 3'h4, 3'h1, 5'h07, 3'h4, 3'h1, 5'h07);
            pkt(2'h0, 1'b1, 1'b0, 3'h6, 3'h1, 5'h07, 3'h6, 3'h1, 5'h07);
        end
    endtask
    task automatic t_remark();
        for (int r = 0; r < 4; r++) begin
            set_byte(8'h42, `OFFS_PRIO_BYTE, {2'h3, 3'h5, 1'b1, r[1:0]});
            pkt(2'h1, 1'b1, 1'b1, 3'h1, 3'h7, 5'h10, 3'h5, {1'b0, r[1:0]}, 5'h10);
        end
        pkt(2'h1, 1'b1, 1'b0, 3'h1, 3'h7, 5'h10, 3'h1, 3'h3, 5'h10);
        set_byte(8'h42, `OFFS_PRIO_BYTE, 8'hd3);
        pkt(2'h1, 1'b1, 1'b1, 3'h1, 3'h6, 5'h10, 3'h2, 3'h6, 5'h10);
    endtask
    task automatic t_map();
        logic [4:0] em [4];
        em = '{5'h07, 5'h17, 5'h02, 5'h12};
        for (int m = 0; m < 4; m++) begin
            set_byte(8'h44, `OFFS_MAP_BYTE, {1'b0, m[1:0], 5'h1a});
            pkt(2'h3, 1'b1, 1'b1, 3'h3, 3'h2, 5'h07, 3'h3, 3'h2, em[m]);
        end
        pkt(2'h3, 1'b1, 1'b1, 3'h3, 3'h2, 5'h0d, 3'h3, 3'h2, 5'h12);
    endtask
    task automatic t_nomatch();
        set_byte(8'h44, `OFFS_PRIO_BYTE, 8'hff);
        pkt(2'h3, 1'b0, 1'b1, 3'h2, 3'h5, 5'h05, 3'h2, 3'h5, 5'h05);
        pkt(2'h3, 1'b1, 1'b1, 3'h2, 3'h5, 5'h05, 3'h7, 3'h3, 5'h12);
        pkt(2'h2, 1'b1, 1'b1, 3'h2, 3'h5, 5'h05, 3'h2, 3'h5, 5'h05);
    endtask
    // ==========================================
    // run control
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #50000;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_access();
        t_prio();
        t_remark();
        t_map();
        t_nomatch();
        give_verdict();
    end
endmodule
